// ===== design/rsc_pkg.sv
package rsc_pkg;

    // register map on the APB byte address
    localparam int unsigned ADDR_W          = 12;
    localparam logic [11:0] CAUSE_OFFSET    = 12'h000;
    localparam logic [11:0] CONTROL_OFFSET  = 12'h004;

    // reset control register fields
    localparam int unsigned CTL_LOC_EN_BIT  = 0;
    localparam int unsigned CTL_LOL_EN_BIT  = 1;
    localparam int unsigned CTL_CFG_EN_BIT  = 2;
    localparam int unsigned CTL_SOFT_BIT    = 7;
    localparam logic [7:0]  CTL_RESET       = 8'h00;
    localparam logic [7:0]  CTL_WRITE_MASK  = 8'h87;

    // cause register: power-on leaves power-on and low-voltage set
    localparam logic [7:0]  CAUSE_RESET     = 8'h48;

    // sequencing counts, in system clock cycles
    localparam int unsigned STRETCH_CYCLES  = 512;
    localparam int unsigned EXT_FILTER_EDGES = 4;

    // reset cause layout, bit 7 down to bit 0
    typedef struct packed {
        logic reserved7;
        logic low_voltage;
        logic software;
        logic reserved4;
        logic power_on;
        logic external;
        logic clock_loss;
        logic lock_loss;
    } rsc_cause_s;

    // pins and status levels from outside the clock domain
    typedef struct packed {
        logic ext_reset_in_n;
        logic stop_mode;
        logic pll_mode;
        logic pll_locked;
        logic pll_clock_fail;
        logic pll_lock_lost;
        logic low_voltage;
        logic power_on;
        logic config_select_pin;
    } rsc_pins_s;

    // supply reads as bad until the synchroniser holds real pin levels
    localparam logic [8:0]  PINS_RESET      = 9'h102;

endpackage

// ===== design/rsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_sync #(
    parameter int unsigned        WIDTH     = 9,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    initial begin
        if (WIDTH < 1) begin
            $error("rsc_sync: WIDTH must be at least 1");
        end
    end

    // first stage feeds only the second stage
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            logic meta;
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta      <= RESET_VAL[g];
                    o_sync[g] <= RESET_VAL[g];
                end else begin
                    meta      <= i_async[g];
                    o_sync[g] <= meta;
                end
            end
        end
    endgenerate

endmodule // rsc_sync

`default_nettype wire

// ===== design/rsc_stretch_cnt.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_stretch_cnt #(
    parameter int unsigned CYCLES = rsc_pkg::STRETCH_CYCLES
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // control
    input  wire logic i_restart,
    input  wire logic i_run,
    // status
    output logic      o_done
);

    localparam int unsigned CNT_W = $clog2(CYCLES + 1);

    initial begin
        if (CYCLES < 2) begin
            $error("rsc_stretch_cnt: CYCLES must be at least 2");
        end
    end

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    // restart wins so every entry counts the full stretch
    assign next_count = i_restart ? '0
                      : (i_run && !o_done) ? count + CNT_W'(1) : count;
    // done in the last counted cycle, so the state stays exactly CYCLES
    assign o_done     = (count == CNT_W'(CYCLES - 1));

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule // rsc_stretch_cnt

`default_nettype wire

// ===== design/rsc_top.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module rsc_top #(
    parameter int unsigned STRETCH_CYCLES = rsc_pkg::STRETCH_CYCLES,
    parameter int unsigned FILTER_EDGES   = rsc_pkg::EXT_FILTER_EDGES
) (
    // clock and reset
    input  wire logic                       I_CLK,
    input  wire logic                       I_RST_N,
    // apb slave
    input  wire logic                       I_PSEL,
    input  wire logic                       I_PENABLE,
    input  wire logic                       I_PWRITE,
    input  wire logic [rsc_pkg::ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]                I_PWDATA,
    input  wire logic [3:0]                 I_PSTRB,
    output logic      [31:0]                O_PRDATA,
    output logic                            O_PREADY,
    output logic                            O_PSLVERR,
    // reset sources and clock status
    input  wire logic                       I_EXT_RESET_IN_N,
    input  wire logic                       I_STOP_MODE,
    input  wire logic                       I_PLL_MODE,
    input  wire logic                       I_PLL_LOCKED,
    input  wire logic                       I_PLL_CLOCK_FAIL,
    input  wire logic                       I_PLL_LOCK_LOST,
    input  wire logic                       I_LOW_VOLTAGE,
    input  wire logic                       I_POWER_ON,
    input  wire logic                       I_CONFIG_SELECT_PIN,
    // bus cycle in progress
    input  wire logic                       I_BUS_CYCLE_END,
    output logic                            O_MONITOR_FORCE,
    // reset outputs
    output logic                            O_RESET_OUT_N,
    output logic                            O_SYS_RESET_N,
    // latched configuration
    output logic                            O_CONFIG_VALUE,
    output logic                            O_CONFIG_VALID
);

    initial begin
        if (STRETCH_CYCLES < 2 || FILTER_EDGES < 1 || FILTER_EDGES > 15) begin
            $error("rsc_top: unsupported STRETCH_CYCLES or FILTER_EDGES");
        end
    end

    typedef enum logic [2:0] {
        ST_POWER_UP,
        ST_RUN,
        ST_BUS_WAIT,
        ST_WAIT_NEGATE,
        ST_WAIT_LOCK,
        ST_COUNT,
        ST_CONFIG
    } rsc_state_e;

    // reset release through two flops
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // pin synchronisers
    rsc_pkg::rsc_pins_s pins_raw;
    rsc_pkg::rsc_pins_s pins;
    logic [8:0]         pins_sync;

    assign pins_raw = '{
        ext_reset_in_n:    I_EXT_RESET_IN_N,
        stop_mode:         I_STOP_MODE,
        pll_mode:          I_PLL_MODE,
        pll_locked:        I_PLL_LOCKED,
        pll_clock_fail:    I_PLL_CLOCK_FAIL,
        pll_lock_lost:     I_PLL_LOCK_LOST,
        low_voltage:       I_LOW_VOLTAGE,
        power_on:          I_POWER_ON,
        config_select_pin: I_CONFIG_SELECT_PIN
    };

    rsc_sync #(
        .WIDTH     (9),
        .RESET_VAL (rsc_pkg::PINS_RESET)
    ) u_sync (
        .i_clk   (I_CLK),
        .i_rst_n (rst_n),
        .i_async (pins_raw),
        .o_sync  (pins_sync)
    );

    assign pins = rsc_pkg::rsc_pins_s'(pins_sync);

    // registers
    rsc_state_e          state;
    rsc_state_e          next_state;
    rsc_pkg::rsc_cause_s cause;
    rsc_pkg::rsc_cause_s next_cause;
    logic [7:0]          control;
    logic [7:0]          next_control;
    logic [3:0]          ext_low_count;
    logic                ext_req;
    logic                pend_ext;
    logic                pend_soft;
    logic                stop_ext_seen;
    logic                out_n;
    logic                config_value;
    logic                config_valid;
    logic [31:0]         prdata;

    // control fields
    wire loc_en   = control[rsc_pkg::CTL_LOC_EN_BIT];
    wire lol_en   = control[rsc_pkg::CTL_LOL_EN_BIT];
    wire cfg_en   = control[rsc_pkg::CTL_CFG_EN_BIT];
    wire soft_req = control[rsc_pkg::CTL_SOFT_BIT];

    // source classification on synchronised levels
    wire supply_bad = pins.power_on | pins.low_voltage;
    wire clk_loss   = pins.pll_mode & loc_en & pins.pll_clock_fail;
    wire lock_loss  = pins.pll_mode & lol_en & pins.pll_lock_lost;
    wire any_loss   = clk_loss | lock_loss;
    wire lock_ok    = ~pins.pll_mode | pins.pll_locked;
    wire ext_low    = ~pins.ext_reset_in_n;
    wire sync_src   = (ext_req & ~pins.stop_mode) | soft_req;
    wire async_int  = any_loss | stop_ext_seen;

    // raw gate so catastrophic sources pull reset without a clock edge
    wire stop_ext_raw  = I_STOP_MODE & ~I_EXT_RESET_IN_N;
    wire async_now_raw = I_POWER_ON | I_LOW_VOLTAGE | stop_ext_raw
                       | (I_PLL_MODE & ((I_PLL_CLOCK_FAIL & loc_en)
                       | (I_PLL_LOCK_LOST & lol_en)));

    // external input filter: held low four rising edges
    wire [3:0] next_ext_low_count = !ext_low ? 4'h0
                                  : (ext_req ? ext_low_count : ext_low_count + 4'h1);
    wire       next_ext_req       = ext_low && (ext_low_count >= 4'(FILTER_EDGES - 1));

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_low_count <= 4'h0;
            ext_req       <= 1'b0;
        end else begin
            ext_low_count <= next_ext_low_count;
            ext_req       <= next_ext_req;
        end
    end

    // stop mode has no clock: the pin combination sets this flop directly
    always_ff @(posedge I_CLK or negedge rst_n or posedge stop_ext_raw) begin
        if (!rst_n) begin
            stop_ext_seen <= 1'b0;
        end else if (stop_ext_raw) begin
            stop_ext_seen <= 1'b1;
        end else if (state != ST_RUN) begin
            stop_ext_seen <= 1'b0;
        end
    end

    // stretch counter
    wire count_restart = (next_state == ST_COUNT) && (state != ST_COUNT);
    wire count_done;

    rsc_stretch_cnt #(
        .CYCLES (STRETCH_CYCLES)
    ) u_stretch (
        .i_clk     (I_CLK),
        .i_rst_n   (rst_n),
        .i_restart (count_restart),
        .i_run     (state == ST_COUNT),
        .o_done    (count_done)
    );

    // sequencer
    always_comb begin
        next_state = state;
        next_cause = cause;
        case (state)
            ST_POWER_UP: begin
                if (!supply_bad && lock_ok) begin
                    next_state = ST_COUNT;
                end
            end
            ST_RUN: begin
                if (async_int) begin
                    next_cause            = '0;
                    next_cause.clock_loss = clk_loss;
                    next_cause.lock_loss  = lock_loss;
                    next_cause.external   = stop_ext_seen;
                    next_state = stop_ext_seen ? ST_WAIT_NEGATE : ST_WAIT_LOCK;
                end else if (sync_src) begin
                    next_state = ST_BUS_WAIT;
                end
            end
            ST_BUS_WAIT: begin
                if (any_loss || I_BUS_CYCLE_END) begin
                    next_cause            = '0;
                    next_cause.external   = pend_ext;
                    next_cause.software   = pend_soft;
                    next_cause.clock_loss = clk_loss;
                    next_cause.lock_loss  = lock_loss;
                    next_state = ST_WAIT_NEGATE;
                end
            end
            ST_WAIT_NEGATE: begin
                if (!ext_low) begin
                    next_state = ST_WAIT_LOCK;
                end
            end
            ST_WAIT_LOCK: begin
                if (ext_req) begin
                    next_state = ST_WAIT_NEGATE;
                end else if (lock_ok && !any_loss) begin
                    next_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (ext_req) begin
                    next_state = ST_WAIT_NEGATE;
                end else if (any_loss || !lock_ok) begin
                    next_state = ST_WAIT_LOCK;
                end else if (count_done) begin
                    next_state = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_POWER_UP;
            end
        endcase
        // supply events override every state
        if (pins.power_on) begin
            next_cause             = '0;
            next_cause.power_on    = 1'b1;
            next_cause.low_voltage = 1'b1;
            next_state             = ST_POWER_UP;
        end else if (pins.low_voltage && !(state == ST_POWER_UP && cause.power_on)) begin
            next_cause             = '0;
            next_cause.low_voltage = 1'b1;
            next_state             = ST_POWER_UP;
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_POWER_UP;
            cause <= rsc_pkg::rsc_cause_s'(rsc_pkg::CAUSE_RESET);
        end else begin
            state <= next_state;
            cause <= next_cause;
        end
    end

    // pending synchronous requests caught on entry to the bus wait
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pend_ext  <= 1'b0;
            pend_soft <= 1'b0;
        end else if (state == ST_RUN && next_state == ST_BUS_WAIT) begin
            pend_ext  <= ext_req;
            pend_soft <= soft_req;
        end
    end

    // reset out low outside run and bus wait; bus wait keeps the bus alive
    wire next_out_n = (next_state == ST_RUN) || (next_state == ST_BUS_WAIT);

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            out_n <= 1'b0;
        end else begin
            out_n <= next_out_n;
        end
    end

    assign O_RESET_OUT_N   = out_n & ~async_now_raw;
    assign O_SYS_RESET_N   = out_n & ~async_now_raw;
    assign O_MONITOR_FORCE = (state == ST_BUS_WAIT);

    // configuration pin sampled just before release
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            config_value <= 1'b0;
            config_valid <= 1'b0;
        end else if (state == ST_CONFIG && cfg_en) begin
            config_value <= pins.config_select_pin;
            config_valid <= 1'b1;
        end
    end

    assign O_CONFIG_VALUE = config_value;
    assign O_CONFIG_VALID = config_valid;

    // apb decode
    wire apb_setup  = I_PSEL & ~I_PENABLE;
    wire apb_access = I_PSEL & I_PENABLE;
    wire hit_cause  = (I_PADDR == rsc_pkg::CAUSE_OFFSET);
    wire hit_ctl    = (I_PADDR == rsc_pkg::CONTROL_OFFSET);
    wire ctl_write  = apb_access & I_PWRITE & hit_ctl & I_PSTRB[0];
    wire [31:0] read_mux = hit_cause ? {24'h000000, cause}
                         : hit_ctl   ? {24'h000000, control}
                         : 32'h00000000;

    // software request: a write still lands even as the reset clears it
    wire soft_clear = (state == ST_RUN) && (next_state == ST_BUS_WAIT) && soft_req;

    always_comb begin
        next_control = control;
        if (soft_clear) begin
            next_control[rsc_pkg::CTL_SOFT_BIT] = 1'b0;
        end
        if (ctl_write) begin
            next_control = I_PWDATA[7:0] & rsc_pkg::CTL_WRITE_MASK;
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            control <= rsc_pkg::CTL_RESET;
        end else begin
            control <= next_control;
        end
    end

    // read data registered in the setup phase; cause ignores writes
    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (apb_setup) begin
            prdata <= I_PWRITE ? 32'h00000000 : read_mux;
        end
    end

    assign O_PRDATA  = prdata;
    assign O_PREADY  = apb_access;
    assign O_PSLVERR = apb_access & ~(hit_cause | hit_ctl);

endmodule // rsc_top

`default_nettype wire

// ===== tb/rsc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_top_monitor #(
    parameter int unsigned STRETCH_CYCLES = rsc_pkg::STRETCH_CYCLES
) (
    // clock, reset and apb
    input wire logic                       I_CLK,
    input wire logic                       I_RST_N,
    input wire logic                       I_PSEL,
    input wire logic                       I_PENABLE,
    input wire logic                       I_PWRITE,
    input wire logic [rsc_pkg::ADDR_W-1:0] I_PADDR,
    input wire logic [31:0]                O_PRDATA,
    input wire logic                       O_PREADY,
    input wire logic                       O_PSLVERR,
    // sources and sequencing
    input wire logic                       I_EXT_RESET_IN_N,
    input wire logic                       I_POWER_ON,
    input wire logic                       I_LOW_VOLTAGE,
    input wire logic                       I_PLL_LOCK_LOST,
    input wire logic                       I_PLL_CLOCK_FAIL,
    input wire logic                       I_BUS_CYCLE_END,
    input wire logic                       O_MONITOR_FORCE,
    input wire logic                       O_RESET_OUT_N,
    input wire logic                       O_SYS_RESET_N
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    // saturates rather than wraps, so a long hold never looks short
    logic [15:0] low_cnt;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) low_cnt <= 16'h0000;
        else if (O_RESET_OUT_N) low_cnt <= 16'h0000;
        else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
    end

    stretch_len_a: assert property (
        $rose(O_RESET_OUT_N) |-> low_cnt >= 16'(STRETCH_CYCLES))
        else $error("reset out released before the stretch ran out");
    outs_equal_a: assert property (O_SYS_RESET_N == O_RESET_OUT_N)
        else $error("system reset and reset out differ");
    supply_hold_a: assert property ((I_POWER_ON || I_LOW_VOLTAGE) |-> !O_RESET_OUT_N)
        else $error("reset out high during a supply fault");
    bus_end_a: assert property (O_MONITOR_FORCE && I_BUS_CYCLE_END |=> !O_RESET_OUT_N)
        else $error("reset out not asserted after bus cycle end");
    force_hold_a: assert property (
        O_MONITOR_FORCE && !I_BUS_CYCLE_END
        && !(I_POWER_ON || I_LOW_VOLTAGE || I_PLL_LOCK_LOST || I_PLL_CLOCK_FAIL)
        |=> O_MONITOR_FORCE)
        else $error("monitor force dropped before bus cycle end");
    negate_wait_a: assert property (
        !I_EXT_RESET_IN_N && !O_RESET_OUT_N |=> !O_RESET_OUT_N)
        else $error("reset out released while external input low");
    zero_wait_a: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
        else $error("apb access not answered at once");
    unmapped_err_a: assert property (O_PREADY |-> O_PSLVERR ==
        !(I_PADDR == rsc_pkg::CAUSE_OFFSET || I_PADDR == rsc_pkg::CONTROL_OFFSET))
        else $error("slave error does not match the address map");
    cause_bits_a: assert property (
        O_PREADY && !I_PWRITE && I_PADDR == rsc_pkg::CAUSE_OFFSET
        |-> O_PRDATA[31:7] == 25'h0000000 && !O_PRDATA[4])
        else $error("reserved cause bits read as one");
endmodule // rsc_top_monitor

bind rsc_top rsc_top_monitor #(.STRETCH_CYCLES(STRETCH_CYCLES)) rsc_top_monitor_i (
    .I_CLK, .I_RST_N, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PRDATA, .O_PREADY,
    .O_PSLVERR, .I_EXT_RESET_IN_N, .I_POWER_ON, .I_LOW_VOLTAGE, .I_PLL_LOCK_LOST,
    .I_PLL_CLOCK_FAIL, .I_BUS_CYCLE_END, .O_MONITOR_FORCE, .O_RESET_OUT_N, .O_SYS_RESET_N);

`default_nettype wire

// ===== tb/rsc_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_far_side (
    // clock and commands
    input  wire logic       i_clk,
    input  wire logic       i_go,
    input  wire logic [7:0] i_hold,
    input  wire logic [7:0] i_bus_delay,
    // bus side
    input  wire logic       i_force,
    output logic            o_ext_reset_in_n,
    output logic            o_bus_cycle_end
);
    logic [7:0] ext_cnt = 8'h00;
    logic [7:0] bus_cnt = 8'h00;

    // pulled-up pin: high whenever nobody holds it down
    assign o_ext_reset_in_n = (ext_cnt == 8'h00);
    // a stuck cycle ends only after the programmed delay
    assign o_bus_cycle_end  = i_force && (bus_cnt == i_bus_delay);

    always @(posedge i_clk) begin
        ext_cnt <= i_go ? i_hold : ext_cnt - ((ext_cnt != 8'h00) ? 8'h01 : 8'h00);
        bus_cnt <= i_force ? bus_cnt + 8'h01 : 8'h00;
    end
endmodule // rsc_far_side

`default_nettype wire

// ===== tb/rsc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_top_bench;
    localparam int unsigned STRETCH = 8;
    localparam logic [11:0] CAUSE   = rsc_pkg::CAUSE_OFFSET;
    localparam logic [11:0] CTRL    = rsc_pkg::CONTROL_OFFSET;

    logic        clk, rst_n, psel, penable, pwrite, stop, pll_mode, locked, err;
    logic        clk_fail, lock_lost, low_v, pon, go, force_mon, bus_end, ext_n;
    logic        out_n, sys_n, cfg_v, cfg_ok, pready, pslverr, cfg_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  hold, bus_dly;
    int          fail_count = 0;
    int          checks = 0;
    int          cyc = 0;

    rsc_top #(.STRETCH_CYCLES(STRETCH)) rsc_top_i (
        .I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_EXT_RESET_IN_N(ext_n), .I_STOP_MODE(stop), .I_PLL_MODE(pll_mode),
        .I_PLL_LOCKED(locked), .I_PLL_CLOCK_FAIL(clk_fail), .I_PLL_LOCK_LOST(lock_lost),
        .I_LOW_VOLTAGE(low_v), .I_POWER_ON(pon), .I_CONFIG_SELECT_PIN(cfg_pin),
        .I_BUS_CYCLE_END(bus_end), .O_MONITOR_FORCE(force_mon), .O_RESET_OUT_N(out_n),
        .O_SYS_RESET_N(sys_n), .O_CONFIG_VALUE(cfg_v), .O_CONFIG_VALID(cfg_ok));

    rsc_far_side rsc_far_side_i (.i_clk(clk), .i_go(go), .i_hold(hold),
        .i_bus_delay(bus_dly), .i_force(force_mon), .o_ext_reset_in_n(ext_n),
        .o_bus_cycle_end(bus_end));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // whole run is a few hundred cycles; this only cuts a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end

    task test_done();
        if (fail_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    task wait_out(input logic lvl, input int n);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (out_n !== lvl && k < n);
        chk({31'h0, out_n}, {31'h0, lvl});
    endtask

    task ext_pulse(input logic [7:0] len);
        @(posedge clk);
        hold <= len;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask

    task power_up();
        wait_out(1'b1, 300);
        rd_chk(CAUSE, 32'h00000048);
        apb(1'b1, CAUSE, 32'hFFFFFFFF);
        rd_chk(CAUSE, 32'h00000048);
        rd_chk(12'h008, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        chk({30'h0, cfg_ok, cfg_v}, 32'h00000000);
    endtask

    // a loss with its enable clear, or outside PLL mode, starts no reset
    task loss_masked(input logic mode);
        @(posedge clk);
        {pll_mode, lock_lost, clk_fail} <= {mode, 2'b11};
        repeat (6) @(negedge clk);
        chk({31'h0, out_n}, 32'h00000001);
        @(posedge clk);
        {pll_mode, lock_lost, clk_fail} <= 3'b100;
    endtask

    task sw_reset();
        bus_dly <= 8'h06;
        apb(1'b1, CTRL, 32'h00000080);
        for (int k = 0; k < 8 && force_mon !== 1'b1; k++) @(negedge clk);
        chk({31'h0, force_mon}, 32'h00000001);
        chk({31'h0, out_n}, 32'h00000001);
        wait_out(1'b0, 12);
        wait_out(1'b1, 300);
        rd_chk(CAUSE, 32'h00000020);
        apb(1'b0, CTRL, 32'h00000000);
        chk({31'h0, rd[7]}, 32'h00000000);
    endtask

    task ext_reset();
        bus_dly <= 8'h00;
        ext_pulse(8'h02);
        repeat (12) @(negedge clk);
        chk({30'h0, out_n, force_mon}, 32'h00000002);
        ext_pulse(8'h06);
        wait_out(1'b0, 16);
        wait_out(1'b1, 300);
        rd_chk(CAUSE, 32'h00000004);
    endtask

    // src: power-on, low voltage, lock loss, clock loss, stop-mode external
    task async_case(input logic [4:0] src, input logic [7:0] exp);
        @(posedge clk);
        {pon, low_v, lock_lost, clk_fail, stop} <= src;
        locked <= ~(src[2] | src[1]);
        hold <= 8'h06;
        go <= src[0];
        wait_out(1'b0, src[0] ? 6 : 1);
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
        {pon, low_v, lock_lost, clk_fail, stop} <= 5'h00;
        locked <= 1'b1;
        wait_out(1'b1, 300);
        rd_chk(CAUSE, {24'h0, exp});
    endtask

    task relock();
        int n;
        async_case(5'b00100, 8'h01);
        @(posedge clk);
        lock_lost <= 1'b1;
        locked <= 1'b0;
        repeat (3) @(posedge clk);
        lock_lost <= 1'b0;
        locked <= 1'b1;
        repeat (5) @(posedge clk);
        lock_lost <= 1'b1;
        locked <= 1'b0;
        repeat (3) @(posedge clk);
        lock_lost <= 1'b0;
        locked <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (out_n !== 1'b1 && n < 300);
        chk({31'h0, n > STRETCH && n < 300}, 32'h00000001);
    endtask

    initial begin
        {psel, penable, pwrite, stop, go, clk_fail, lock_lost, low_v, pon, cfg_pin} = 10'h000;
        pll_mode = 1'b1;
        locked = 1'b1;
        rst_n = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        hold = 8'h00;
        bus_dly = 8'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        power_up();
        sw_reset();
        ext_reset();
        loss_masked(1'b1);
        apb(1'b1, CTRL, 32'h00000007);
        loss_masked(1'b0);
        async_case(5'b00010, 8'h02);
        chk({30'h0, cfg_ok, cfg_v}, 32'h00000002);
        cfg_pin <= 1'b1;
        relock();
        chk({30'h0, cfg_ok, cfg_v}, 32'h00000003);
        async_case(5'b00001, 8'h04);
        async_case(5'b01000, 8'h40);
        async_case(5'b10000, 8'h48);
        test_done();
    end
endmodule // rsc_top_bench

`default_nettype wire
